/* logic/sox_pkg.sv */
// constants and carrier types for the serial octal port expander
// What this block does
// - four 8-bit registers: direction, input level, output level, polarity inversion.
// - after power-up all pins are inputs.
// - a set polarity bit inverts the matching input register read bit.
// - every register is readable over the serial bus.
// - reset pin low restores all registers and the bus state machine.
// - power-on reset holds the block until port supply valid, then defaults.
// - alert asserts low when any input pin differs from its stored input value.
// - rising or falling edge on an input pin raises the alert.
// - alert clears when the pin returns, or when the input port is read.
// - read clearing takes effect at the acknowledge bit after clock rising edge.
// - a change during the acknowledge pulse of a read may be lost.
// - after clearing, each further input change raises the alert again.
// - other devices' traffic leaves alert untouched; output pins never alert.
// - switching a pin from output to input may raise a spurious alert.
// - alert output is open-drain: pulls low or releases, never drives high.
// - an input pin has both drivers off, high-impedance.
// - an output pin is driven by its output register bit.
// - one address-select input chooses between two target addresses.
// - a START begins a transfer from any bus state, so a repeated start needs no STOP.
// - address is 0x20 when select low, 0x21 when high; last bit is read.
// - command byte after write address is the pointer; 0..3 select registers.
// - input register writes do nothing; reads give pin levels, inverted where the polarity bit is set.
// - output register reads return the stored flip-flops, not the pins.
`default_nettype none
package sox_pkg;
   localparam logic [6:0] ADDR_BASE  = 7'h20;
   localparam logic [1:0] REG_INPUT  = 2'h0;
   localparam logic [1:0] REG_OUTPUT = 2'h1;
   localparam logic [1:0] REG_POLAR  = 2'h2;
   localparam logic [1:0] REG_DIR    = 2'h3;
   localparam logic [7:0] RST_OUTPUT = 8'hFF;
   localparam logic [7:0] RST_POLAR  = 8'h00;
   localparam logic [7:0] RST_DIR    = 8'hFF;
   localparam int unsigned CLK_MHZ   = 100;
   localparam int unsigned ALERT_NS  = 4000;
   localparam int unsigned ALERT_CYC = ALERT_NS * CLK_MHZ / 1000;

   typedef enum logic [6:0] {
      SOX_IDLE = 7'h01,
      SOX_ADDR = 7'h02,
      SOX_AACK = 7'h04,
      SOX_WBYT = 7'h08,
      SOX_WACK = 7'h10,
      SOX_RBYT = 7'h20,
      SOX_RACK = 7'h40
   } sox_state_t;

   typedef struct packed {
      logic [7:0] output_q;
      logic [7:0] polar_q;
      logic [7:0] dir_q;
      logic [7:0] in_q;
      logic [1:0] ptr_q;
   } sox_regs_t;

   typedef struct packed {
      sox_state_t state_q;
      logic [7:0] shift_q;
      logic [3:0] bitcnt_q;
      logic       rnw_q;
      logic       first_q;
      logic       sda_oe_q;
      logic       readin_q;
   } sox_bus_t;

   typedef struct packed {
      logic [1:0] scl_s;
      logic [1:0] sda_s;
      logic [1:0] scl_r;
      logic [1:0] sda_r;
      logic [7:0] pin_s0;
      logic [7:0] pin_s1;
   } sox_sync_t;

   typedef struct packed {
      sox_regs_t regs;
      sox_bus_t  bus;
      sox_sync_t sync;
   } sox_state_all_t;
endpackage
`default_nettype wire

/* logic/sox_expander.sv */
// serial octal port expander: two-wire target, port registers and change alert
`default_nettype none
module sox_expander (
   input  wire logic       sys_clk,       // 100 MHz system clock
   input  wire logic       rstn,          // async reset, low active
   input  wire logic       clk_en,        // freezes all state while low
   input  wire logic       rst_pin_n,     // device reset pin, low active
   input  wire logic       supply_ok,     // port supply valid from power monitor
   input  wire logic       addr_sel,      // target address select
   input  wire logic       scl_in,        // serial clock level
   input  wire logic       sda_in,        // serial data level
   output logic            sda_out,       // serial data drive value, always low
   output logic            sda_oe,        // high while pulling data low
   input  wire logic [7:0] expander_port_pins_in,  // port pin levels
   output logic [7:0]      expander_port_pins_out, // port pin drive values
   output logic [7:0]      expander_port_pins_oe,  // high where pin driven
   output logic            alert_out,     // alert drive value, always low
   output logic            alert_oe       // high while pulling alert low
);
   sox_pkg::sox_state_all_t s_q, s_d;
   logic       blk_rst;
   logic       scl_rise, scl_fall, start_c, stop_c, sda_v, scl_v;
   logic [7:0] pins, rdata, diff;
   logic [6:0] my_addr;
   logic       alert_raw;

   // ******************************************************
   // combined reset and bus condition decode
   // ******************************************************
   logic [1:0] rsync_q;
   logic       rst_hold_q;
   logic [1:0] asel_q;
   logic       addr_sel_q;

   // both pin and power monitor force defaults, synchronously sampled
   assign blk_rst  = rst_hold_q;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rsync_q    <= 2'h0;
         rst_hold_q <= 1'b1;
      end else if (clk_en) begin
         rsync_q    <= {rsync_q[0], rst_pin_n & supply_ok};
         rst_hold_q <= ~rsync_q[1];
      end
   end

   assign scl_v    = s_q.sync.scl_s[1];
   assign sda_v    = s_q.sync.sda_s[1];
   assign scl_rise = scl_v & ~s_q.sync.scl_r[0];
   assign scl_fall = ~scl_v & s_q.sync.scl_r[0];
   assign start_c  = scl_v & s_q.sync.scl_r[0] & ~sda_v & s_q.sync.sda_r[0];
   assign stop_c   = scl_v & s_q.sync.scl_r[0] & sda_v & ~s_q.sync.sda_r[0];
   assign pins     = s_q.sync.pin_s1;
   assign my_addr  = sox_pkg::ADDR_BASE | {6'h00, addr_sel_q};

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         asel_q     <= 2'h0;
         addr_sel_q <= 1'b0;
      end else if (clk_en) begin
         asel_q     <= {asel_q[0], addr_sel};
         addr_sel_q <= asel_q[1];
      end
   end

   function automatic logic [7:0] sox_read(input sox_pkg::sox_regs_t r, input logic [7:0] p);
      case (r.ptr_q)
         sox_pkg::REG_INPUT:  sox_read = p ^ r.polar_q;
         sox_pkg::REG_OUTPUT: sox_read = r.output_q;
         sox_pkg::REG_POLAR:  sox_read = r.polar_q;
         default:             sox_read = r.dir_q;
      endcase
   endfunction

   assign rdata     = sox_read(s_q.regs, pins);
   assign diff      = (pins ^ s_q.regs.in_q) & s_q.regs.dir_q;
   assign alert_raw = |diff;

   // ******************************************************
   // next-state logic
   // ******************************************************
   always_comb begin
      s_d = s_q;
      s_d.sync.scl_s  = {s_q.sync.scl_s[0], scl_in};
      s_d.sync.sda_s  = {s_q.sync.sda_s[0], sda_in};
      s_d.sync.scl_r  = {s_q.sync.scl_r[0], scl_v};
      s_d.sync.sda_r  = {s_q.sync.sda_r[0], sda_v};
      s_d.sync.pin_s0 = expander_port_pins_in;
      s_d.sync.pin_s1 = s_q.sync.pin_s0;
      if (start_c) begin
         s_d.bus.state_q  = sox_pkg::SOX_ADDR;
         s_d.bus.bitcnt_q = 4'h0;
         s_d.bus.sda_oe_q = 1'b0;
      end else if (stop_c) begin
         s_d.bus.state_q  = sox_pkg::SOX_IDLE;
         s_d.bus.sda_oe_q = 1'b0;
      end else begin
         case (s_q.bus.state_q)
            sox_pkg::SOX_IDLE: s_d.bus.sda_oe_q = 1'b0;
            sox_pkg::SOX_ADDR, sox_pkg::SOX_WBYT: begin
               if (scl_rise) begin
                  s_d.bus.shift_q  = {s_q.bus.shift_q[6:0], sda_v};
                  s_d.bus.bitcnt_q = s_q.bus.bitcnt_q + 4'h1;
               end
               if (scl_fall && s_q.bus.bitcnt_q == 4'h8) begin
                  s_d.bus.bitcnt_q = 4'h0;
                  if (s_q.bus.state_q == sox_pkg::SOX_ADDR) begin
                     if (s_q.bus.shift_q[7:1] == my_addr) begin
                        s_d.bus.rnw_q    = s_q.bus.shift_q[0];
                        s_d.bus.first_q  = 1'b1;
                        s_d.bus.sda_oe_q = 1'b1;
                        s_d.bus.state_q  = sox_pkg::SOX_AACK;
                     end else begin
                        s_d.bus.state_q = sox_pkg::SOX_IDLE;
                     end
                  end else begin
                     if (s_q.bus.first_q)
                        s_d.regs.ptr_q = s_q.bus.shift_q[1:0];
                     else
                        case (s_q.regs.ptr_q)
                           sox_pkg::REG_OUTPUT: s_d.regs.output_q = s_q.bus.shift_q;
                           sox_pkg::REG_POLAR:  s_d.regs.polar_q  = s_q.bus.shift_q;
                           sox_pkg::REG_DIR:    s_d.regs.dir_q    = s_q.bus.shift_q;
                           default:             s_d.regs.dir_q    = s_q.regs.dir_q;
                        endcase
                     s_d.bus.first_q  = 1'b0;
                     s_d.bus.sda_oe_q = 1'b1;
                     s_d.bus.state_q  = sox_pkg::SOX_WACK;
                  end
               end
            end
            sox_pkg::SOX_AACK, sox_pkg::SOX_WACK: begin
               if (scl_fall) begin
                  if (s_q.bus.rnw_q && s_q.bus.state_q == sox_pkg::SOX_AACK) begin
                     s_d.bus.shift_q  = rdata;
                     s_d.bus.readin_q = (s_q.regs.ptr_q == sox_pkg::REG_INPUT);
                     s_d.bus.sda_oe_q = ~rdata[7];
                     s_d.bus.bitcnt_q = 4'h1;
                     s_d.bus.state_q  = sox_pkg::SOX_RBYT;
                  end else begin
                     s_d.bus.sda_oe_q = 1'b0;
                     s_d.bus.bitcnt_q = 4'h0;
                     s_d.bus.state_q  = sox_pkg::SOX_WBYT;
                  end
               end
            end
            sox_pkg::SOX_RBYT: begin
               if (scl_fall) begin
                  if (s_q.bus.bitcnt_q == 4'h8) begin
                     s_d.bus.sda_oe_q = 1'b0;
                     s_d.bus.state_q  = sox_pkg::SOX_RACK;
                  end else begin
                     s_d.bus.sda_oe_q = ~s_q.bus.shift_q[3'(7 - s_q.bus.bitcnt_q)];
                     s_d.bus.bitcnt_q = s_q.bus.bitcnt_q + 4'h1;
                  end
               end
            end
            sox_pkg::SOX_RACK: begin
               if (scl_rise) begin
                  // input snapshot refreshed in the acknowledge pulse clears the alert
                  if (s_q.bus.readin_q)
                     s_d.regs.in_q = pins;
                  if (sda_v)
                     s_d.bus.state_q = sox_pkg::SOX_IDLE;
                  else begin
                     s_d.bus.state_q = sox_pkg::SOX_AACK;
                  end
               end
            end
            default: s_d.bus.state_q = sox_pkg::SOX_IDLE;
         endcase
      end
      if (blk_rst) begin
         s_d.regs.output_q = sox_pkg::RST_OUTPUT;
         s_d.regs.polar_q  = sox_pkg::RST_POLAR;
         s_d.regs.dir_q    = sox_pkg::RST_DIR;
         s_d.regs.ptr_q    = sox_pkg::REG_INPUT;
         s_d.regs.in_q     = pins;
         s_d.bus.state_q   = sox_pkg::SOX_IDLE;
         s_d.bus.sda_oe_q  = 1'b0;
         s_d.bus.bitcnt_q  = 4'h0;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         s_q <= '{regs: '{output_q: sox_pkg::RST_OUTPUT, polar_q: sox_pkg::RST_POLAR,
                          dir_q: sox_pkg::RST_DIR, in_q: 8'h00, ptr_q: 2'h0},
                  bus:  '{state_q: sox_pkg::SOX_IDLE, shift_q: 8'h00, bitcnt_q: 4'h0,
                          rnw_q: 1'b0, first_q: 1'b0, sda_oe_q: 1'b0, readin_q: 1'b0},
                  sync: '{scl_s: 2'h3, sda_s: 2'h3, scl_r: 2'h3, sda_r: 2'h3,
                          pin_s0: 8'h00, pin_s1: 8'h00}};
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   // ******************************************************
   // outputs
   // ******************************************************
   logic alert_q;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn)
         alert_q <= 1'b0;
      else if (clk_en)
         alert_q <= alert_raw & ~blk_rst;
   end
   assign alert_out = 1'b0;
   assign alert_oe  = alert_q;
   assign sda_out   = 1'b0;
   assign sda_oe    = s_q.bus.sda_oe_q;
   assign expander_port_pins_out = s_q.regs.output_q;
   assign expander_port_pins_oe  = ~s_q.regs.dir_q;

   // ******************************************************
   // assertions
   // ******************************************************
   property p_alert_cause;
      @(posedge sys_clk) disable iff (!rstn) (clk_en && !blk_rst && alert_raw) |=> alert_oe;
   endproperty
   a_alert_cause: assert property (p_alert_cause) else $error("alert missed input change");
   property p_alert_quiet;
      @(posedge sys_clk) disable iff (!rstn) (clk_en && diff == 8'h00) |=> !alert_oe;
   endproperty
   a_alert_quiet: assert property (p_alert_quiet) else $error("alert without change");
   property p_out_pins_quiet;
      @(posedge sys_clk) disable iff (!rstn) ((pins ^ s_q.regs.in_q) == ~s_q.regs.dir_q) |-> !alert_raw;
   endproperty
   a_out_pins_quiet: assert property (p_out_pins_quiet) else $error("output pin raised alert");
   property p_hiz_input;
      @(posedge sys_clk) disable iff (!rstn) (expander_port_pins_oe & s_q.regs.dir_q) == 8'h00;
   endproperty
   a_hiz_input: assert property (p_hiz_input) else $error("input pin driven");
   property p_out_value;
      @(posedge sys_clk) disable iff (!rstn) expander_port_pins_out == s_q.regs.output_q;
   endproperty
   a_out_value: assert property (p_out_value) else $error("pin value not output register");
   property p_reset_defaults;
      @(posedge sys_clk) disable iff (!rstn) (clk_en && blk_rst) |=> (s_q.regs.dir_q == sox_pkg::RST_DIR
         && s_q.regs.polar_q == sox_pkg::RST_POLAR && s_q.bus.state_q == sox_pkg::SOX_IDLE);
   endproperty
   a_reset_defaults: assert property (p_reset_defaults) else $error("reset did not restore defaults");
   property p_clear_on_read;
      @(posedge sys_clk) disable iff (!rstn) (clk_en && !blk_rst && !start_c && !stop_c
         && s_q.bus.state_q == sox_pkg::SOX_RACK && scl_rise && s_q.bus.readin_q)
         |=> s_q.regs.in_q == $past(pins);
   endproperty
   a_clear_on_read: assert property (p_clear_on_read) else $error("read did not refresh input");
   property p_stop_idle;
      @(posedge sys_clk) disable iff (!rstn) (clk_en && stop_c && !start_c) |=> s_q.bus.state_q == sox_pkg::SOX_IDLE;
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("stop did not idle bus");
   // the input snapshot moves only in a read acknowledge or in reset
   property p_in_hold;
      @(posedge sys_clk) disable iff (!rstn) (clk_en && !blk_rst && s_q.bus.state_q != sox_pkg::SOX_RACK)
         |=> s_q.regs.in_q == $past(s_q.regs.in_q);
   endproperty
   a_in_hold: assert property (p_in_hold) else $error("input snapshot moved outside a read");
   property p_idle_release;
      @(posedge sys_clk) disable iff (!rstn) (clk_en && s_q.bus.state_q == sox_pkg::SOX_IDLE) |=> !sda_oe;
   endproperty
   a_idle_release: assert property (p_idle_release) else $error("data line held on idle bus");
   property p_addr_ack;
      @(posedge sys_clk) disable iff (!rstn) (clk_en && !blk_rst && !start_c && !stop_c && scl_fall
         && s_q.bus.state_q == sox_pkg::SOX_ADDR && s_q.bus.bitcnt_q == 4'h8
         && s_q.bus.shift_q[7:1] == {sox_pkg::ADDR_BASE[6:1], addr_sel_q}) |=> sda_oe;
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("own address not acknowledged");
   property p_addr_other;
      @(posedge sys_clk) disable iff (!rstn) (clk_en && !blk_rst && !start_c && !stop_c && scl_fall
         && s_q.bus.state_q == sox_pkg::SOX_ADDR && s_q.bus.bitcnt_q == 4'h8
         && s_q.bus.shift_q[7:1] != {sox_pkg::ADDR_BASE[6:1], addr_sel_q})
         |=> (!sda_oe && s_q.bus.state_q == sox_pkg::SOX_IDLE);
   endproperty
   a_addr_other: assert property (p_addr_other) else $error("foreign address answered");
   c_restart: cover property (@(posedge sys_clk) disable iff (!rstn) start_c && s_q.bus.state_q != sox_pkg::SOX_IDLE);
   c_alert: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(alert_oe));
   c_read:  cover property (@(posedge sys_clk) disable iff (!rstn) s_q.bus.state_q == sox_pkg::SOX_RACK);
   c_write: cover property (@(posedge sys_clk) disable iff (!rstn) s_q.bus.state_q == sox_pkg::SOX_WACK);
endmodule
`default_nettype wire

/* tb/sox_bus_ctl.sv */
// two-wire bus controller model facing the expander
`default_nettype none
module sox_bus_ctl (
   output logic     scl,      // serial clock, stands high outside frames
   output logic     sda_pull, // high while pulling data low
   input  wire logic sda_line  // resolved data line with pull-up
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam realtime Q = 31.25;
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   // start or repeated start, begun from an idle bus or from clock low inside a frame
   // data released a quarter bit before clock rises, so a target ack never reads as stop
   task automatic start();
      #Q sda_pull = 1'b0;
      #Q scl = 1'b1;
      #Q sda_pull = 1'b1;
      #Q scl = 1'b0;
   endtask
   task automatic bit_io(input logic b, output logic r);
      #Q sda_pull = ~b;
      #Q scl = 1'b1;
      #Q r = sda_line;
      #Q scl = 1'b0;
   endtask
   task automatic send(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   // last byte gets a not-acknowledge
   task automatic recv(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(last, r);
   endtask
   // stop leaves both lines high: bus idle again
   task automatic stop();
      #Q sda_pull = 1'b1;
      #Q scl = 1'b1;
      #Q sda_pull = 1'b0;
      #(4 * Q);
   endtask
endmodule
`default_nettype wire

/* tb/tb_serial_octal_io_expander.sv */
// self-checking bench for the serial octal port expander
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
   $display("unexpected at %0t: got %0h expected %0h", $time, (a), (b)); end end
module tb_serial_octal_io_expander;
   timeunit 1ns;
   timeprecision 1ps;
   logic       sys_clk, rstn, clk_en, rst_pin_n, supply_ok, addr_sel, scl, ctl_pull;
   logic       sda_out, sda_oe, alert_out, alert_oe;
   logic [7:0] pins_out, pins_oe, pin_ext, d;
   logic [6:0] adr;
   int         n_tests, err_total;
   wire logic       sda_line = ~(ctl_pull | sda_oe);
   wire logic [7:0] pin_lvl  = (pins_oe & pins_out) | (~pins_oe & pin_ext);

   sox_expander uut (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .rst_pin_n(rst_pin_n),
      .supply_ok(supply_ok), .addr_sel(addr_sel), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
      .sda_oe(sda_oe), .expander_port_pins_in(pin_lvl), .expander_port_pins_out(pins_out),
      .expander_port_pins_oe(pins_oe), .alert_out(alert_out), .alert_oe(alert_oe));
   sox_bus_ctl ctl (.scl(scl), .sda_pull(ctl_pull), .sda_line(sda_line));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic wr(input logic [1:0] p, input logic [7:0] v);
      logic a0, a1, a2;
      ctl.start();
      ctl.send({adr, 1'b0}, a0);
      ctl.send({6'h00, p}, a1);
      ctl.send(v, a2);
      ctl.stop();
      `CHK({a0, a1, a2}, 3'h7)
   endtask
   // pointer write, repeated start, read one byte
   task automatic rd(input logic [1:0] p, input logic chk, output logic [7:0] v);
      logic a0, a1, a2;
      ctl.start();
      ctl.send({adr, 1'b0}, a0);
      ctl.send({6'h00, p}, a1);
      ctl.start();
      ctl.send({adr, 1'b1}, a2);
      if (chk) `CHK(alert_oe, 1'b1)
      ctl.recv(1'b1, v);
      ctl.stop();
      if (chk) `CHK(alert_oe, 1'b0)
      `CHK({a0, a1, a2}, 3'h7)
   endtask
   task automatic wait_al(input logic v);
      int n;
      n = 0;
      while (alert_oe !== v && n < 600) begin
         tick(1);
         n++;
      end
   endtask
   task automatic chk_def();
      `CHK(pins_oe, 8'h00)
      `CHK({sda_oe, alert_oe}, 2'h0)
      rd(2'h1, 1'b0, d);
      `CHK(d, 8'hFF)
      rd(2'h2, 1'b0, d);
      `CHK(d, 8'h00)
      rd(2'h3, 1'b0, d);
      `CHK(d, 8'hFF)
   endtask
   task automatic t_port();
      wr(2'h3, 8'h0F);
      wr(2'h1, 8'hA5);
      `CHK(pins_oe, 8'hF0)
      `CHK(pins_out & pins_oe, 8'hA0)
      rd(2'h1, 1'b0, d);
      `CHK(d, 8'hA5)
      wr(2'h0, 8'h00);
      rd(2'h0, 1'b0, d);
      `CHK(d, 8'hAA)
      rd(2'h3, 1'b0, d);
      `CHK(d, 8'h0F)
      wr(2'h2, 8'h3C);
      rd(2'h0, 1'b0, d);
      `CHK(d, 8'h96)
      rd(2'h2, 1'b0, d);
      `CHK(d, 8'h3C)
      wr(2'h2, 8'h00);
      $display("test port done");
   endtask
   task automatic t_alert();
      logic a;
      wr(2'h3, 8'hFF);
      rd(2'h0, 1'b0, d);
      tick(500);
      `CHK(alert_oe, 1'b0)
      pin_ext = 8'h5E;
      wait_al(1'b1);
      `CHK({alert_oe, alert_out}, 2'h2)
      pin_ext = 8'h5A;
      wait_al(1'b0);
      `CHK(alert_oe, 1'b0)
      pin_ext = 8'h58;
      wait_al(1'b1);
      `CHK(alert_oe, 1'b1)
      ctl.start();
      ctl.send({adr ^ 7'h01, 1'b1}, a);
      ctl.stop();
      `CHK({a, alert_oe}, 2'h1)
      rd(2'h0, 1'b1, d);
      `CHK(d, 8'h58)
      pin_ext = 8'h59;
      wait_al(1'b1);
      `CHK(alert_oe, 1'b1)
      rd(2'h0, 1'b1, d);
      wr(2'h3, 8'hFE);
      wr(2'h1, 8'hFE);
      tick(500);
      `CHK({pin_lvl[0], alert_oe}, 2'h0)
      wr(2'h3, 8'hFF);
      $display("test alert done");
   endtask
   task automatic t_addr();
      addr_sel = 1'b1;
      adr = 7'h21;
      tick(10);
      wr(2'h2, 8'h81);
      rd(2'h2, 1'b0, d);
      `CHK(d, 8'h81)
      wr(2'h2, 8'h00);
      addr_sel = 1'b0;
      adr = 7'h20;
      tick(10);
      $display("test address done");
   endtask
   // resets are applied only between transactions
   task automatic t_reset();
      for (int k = 0; k < 2; k++) begin
         wr(2'h1, 8'h3C);
         wr(2'h2, 8'h0F);
         wr(2'h3, 8'h00);
         `CHK(pins_oe, 8'hFF)
         if (k == 0) rst_pin_n = 1'b0;
         else supply_ok = 1'b0;
         tick(10);
         rst_pin_n = 1'b1;
         supply_ok = 1'b1;
         tick(10);
         chk_def();
      end
      $display("test reset done");
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      n_tests = 0;
      err_total = 0;
      rstn = 1'b0;
      clk_en = 1'b1;
      rst_pin_n = 1'b1;
      supply_ok = 1'b1;
      addr_sel = 1'b0;
      adr = 7'h20;
      pin_ext = 8'h5A;
      tick(4);
      rstn = 1'b1;
      tick(10);
      chk_def();
      $display("test defaults done");
      t_port();
      t_alert();
      t_addr();
      t_reset();
      conclude();
   end
   initial begin
      #600000;
      err_total++;
      conclude();
   end
endmodule
`default_nettype wire
